// *** hdl/wdpr_pkg.sv ***
package wdpr_pkg;

  // Special function register addresses
  localparam logic [7:0] ADR_PWR_CTRL = 8'h87;
  localparam logic [7:0] ADR_WDT_CTRL = 8'h8F;
  localparam logic [7:0] ADR_WCNTL = 8'hA6;
  localparam logic [7:0] ADR_WCNTH = 8'hA7;

  // Power control field positions
  localparam int PWR_OFF_BIT = 4;
  localparam int PWR_GF1_BIT = 3;
  localparam int PWR_GF0_BIT = 2;
  localparam int PWR_DOWN_BIT = 1;
  localparam int PWR_IDLE_BIT = 0;

  // Watchdog control field positions
  localparam int WDT_EN_BIT = 7;
  localparam int WDT_CLR_BIT = 6;
  localparam int WDT_IDLE_RUN_BIT = 5;
  localparam int WDT_PS_LSB = 0;

  localparam int WCNT_W = 14;
  localparam int PRESC_W = 8;

  // Machine cycle: six states of two phases each, twelve oscillator periods
  localparam logic [2:0] ST_S5 = 3'h4;
  localparam logic [2:0] ST_S6 = 3'h5;
  localparam logic [2:0] ST_S1 = 3'h0;

  // Machine cycles a watchdog reset is held asserted
  localparam logic [1:0] WDT_RST_MC = 2'h2;

  // Values other SFRs load while the system reset output is high
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_SFR = 8'h00;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PDOWN} wdpr_pm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdpr_bus_t;

  // Last prescaler count for each select code
  function automatic logic [PRESC_W-1:0] wdpr_presc_last(input logic [2:0] sel);
    case (sel)
      3'h0: wdpr_presc_last = 8'h01;
      3'h2: wdpr_presc_last = 8'h03;
      3'h1: wdpr_presc_last = 8'h07;
      3'h3: wdpr_presc_last = 8'h0F;
      3'h4: wdpr_presc_last = 8'h1F;
      3'h5: wdpr_presc_last = 8'h3F;
      3'h6: wdpr_presc_last = 8'h7F;
      default: wdpr_presc_last = 8'hFF;
    endcase
  endfunction

endpackage

// *** hdl/wdpr_rst_deglitch.sv ***
`timescale 1ns/100ps
module wdpr_rst_deglitch #(
  parameter int SAMPLES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sampling
  input wire logic sample_stb,
  input wire logic rst_pin,
  // Filtered level
  output logic rst_lvl_ff
);

  typedef struct packed {
    logic [SAMPLES-1:0] hist;
    logic lvl;
  } wdpr_dg_t;

  wdpr_dg_t st_ff;
  wdpr_dg_t nxt_st;

  // A level changes only after SAMPLES agreeing samples, so a short glitch is dropped
  always_comb begin
    nxt_st = st_ff;
    if (sample_stb) begin
      nxt_st.hist = {st_ff.hist[SAMPLES-2:0], rst_pin};
      if (&nxt_st.hist) begin
        nxt_st.lvl = 1'b1;
      end else if (~|nxt_st.hist) begin
        nxt_st.lvl = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rst_lvl_ff = st_ff.lvl;

endmodule // wdpr_rst_deglitch

// *** hdl/wdpr_ctrl.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Watchdog is divider chain; selected output sets interval
// - Enabled watchdog time-out raises system reset
// - Any reset leaves the watchdog disabled
// - Enable bit starts watchdog; clearing stops reset
// - Clear bit zeroes counter, prescaler, itself at next S6P2
// - Idle-run bit keeps watchdog counting in idle
// - Select code picks divide 2 up to 256
// - Time-out after 2^14 times prescaler machine cycles
// - Reset clears watchdog counter to zero
// - Input clock halved before internal use
// - Idle bit stops processor clock, peripherals run
// - Interrupt or reset ends idle mode
// - Power-down bit stops every clock and oscillator
// - Only reset leaves power-down; interrupts ignored
// - Reset pin sampled once per machine cycle
// - Reset pin deglitched against short pulses
// - Reset initialises power control, other SFRs
// - Power-off flag set on power-on, software clears
// - Power control register at address 87H
module wdpr_ctrl
  import wdpr_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // SFR access
  input wire wdpr_bus_t sfr_bus,
  output logic [7:0] sfr_rdata_ff,
  // Pins and events
  input wire logic rst_pin,
  input wire logic irq_pend,
  // System control
  output logic sys_rst_ff,
  output logic cpu_clk_run_ff,
  output logic periph_clk_run_ff,
  output logic osc_run_ff,
  output logic wdt_timeout_ff
);

  typedef struct packed {
    logic phase;
    logic [2:0] stt;
    wdpr_pm_t pm;
    logic pwr_off;
    logic gf1;
    logic gf0;
    logic en;
    logic clr;
    logic idle_run;
    logic [2:0] ps;
    logic [PRESC_W-1:0] presc;
    logic [WCNT_W-1:0] wcnt;
    logic [1:0] wrst_cnt;
    logic sysrst;
    logic [7:0] rdata;
    logic tout;
    logic cpu_run;
    logic per_run;
    logic osc_run;
  } wdpr_st_t;

  wdpr_st_t st_ff;
  wdpr_st_t nxt_st;
  logic ext_rst_lvl;
  logic osc_on;
  logic mc_tick;
  logic smp_tick;
  logic clr_req;
  logic rst_act;
  logic wdt_run;
  logic presc_tick;

  assign osc_on = (st_ff.pm != PM_PDOWN);
  // Internal state clock runs at half the input rate; a machine cycle ends at S6P2
  assign mc_tick = osc_on && st_ff.phase && (st_ff.stt == ST_S6);
  assign smp_tick = osc_on && st_ff.phase && (st_ff.stt == ST_S5);
  assign clr_req = sfr_bus.wr && (sfr_bus.addr == ADR_WDT_CTRL) && sfr_bus.wdata[WDT_CLR_BIT];
  assign rst_act = ext_rst_lvl || (st_ff.wrst_cnt != 2'h0);
  // Counting pauses when disabled or in idle without the idle-run bit
  assign wdt_run = st_ff.en && (st_ff.pm == PM_RUN || (st_ff.pm == PM_IDLE && st_ff.idle_run));
  assign presc_tick = (st_ff.presc == wdpr_presc_last(st_ff.ps));

  // Pin sampled once per machine cycle; two agreeing samples needed, so one machine cycle of
  // noise never resets and a hold of two machine cycles always does
  wdpr_rst_deglitch #(
    .SAMPLES(2)
  ) u_deglitch (
    .clk(clk),
    .rst_n(rst_n),
    .sample_stb(smp_tick),
    .rst_pin(rst_pin),
    .rst_lvl_ff(ext_rst_lvl)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tout = 1'b0;
    nxt_st.rdata = 8'h00;

    // State sequencer stops with the oscillator
    if (osc_on) begin
      nxt_st.phase = ~st_ff.phase;
      if (st_ff.phase) begin
        nxt_st.stt = (st_ff.stt == ST_S6) ? ST_S1 : st_ff.stt + 3'h1;
      end
    end

    // Register writes
    if (sfr_bus.wr) begin
      case (sfr_bus.addr)
        ADR_PWR_CTRL: begin
          nxt_st.pwr_off = sfr_bus.wdata[PWR_OFF_BIT];
          nxt_st.gf1 = sfr_bus.wdata[PWR_GF1_BIT];
          nxt_st.gf0 = sfr_bus.wdata[PWR_GF0_BIT];
          if (sfr_bus.wdata[PWR_DOWN_BIT]) begin
            nxt_st.pm = PM_PDOWN;
          end else if (sfr_bus.wdata[PWR_IDLE_BIT]) begin
            nxt_st.pm = PM_IDLE;
          end
        end
        ADR_WDT_CTRL: begin
          nxt_st.en = sfr_bus.wdata[WDT_EN_BIT];
          nxt_st.idle_run = sfr_bus.wdata[WDT_IDLE_RUN_BIT];
          nxt_st.ps = sfr_bus.wdata[WDT_PS_LSB +: 3];
          if (clr_req) begin
            nxt_st.clr = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (sfr_bus.rd) begin
      case (sfr_bus.addr)
        ADR_PWR_CTRL: begin
          nxt_st.rdata[PWR_OFF_BIT] = st_ff.pwr_off;
          nxt_st.rdata[PWR_GF1_BIT] = st_ff.gf1;
          nxt_st.rdata[PWR_GF0_BIT] = st_ff.gf0;
          nxt_st.rdata[PWR_DOWN_BIT] = (st_ff.pm == PM_PDOWN);
          nxt_st.rdata[PWR_IDLE_BIT] = (st_ff.pm == PM_IDLE);
        end
        ADR_WDT_CTRL: begin
          nxt_st.rdata[WDT_EN_BIT] = st_ff.en;
          nxt_st.rdata[WDT_CLR_BIT] = st_ff.clr;
          nxt_st.rdata[WDT_IDLE_RUN_BIT] = st_ff.idle_run;
          nxt_st.rdata[WDT_PS_LSB +: 3] = st_ff.ps;
        end
        ADR_WCNTL: begin
          nxt_st.rdata = st_ff.wcnt[7:0];
        end
        ADR_WCNTH: begin
          nxt_st.rdata = {2'h0, st_ff.wcnt[WCNT_W-1:8]};
        end
        default: begin
        end
      endcase
    end

    // Watchdog divider chain advances once per machine cycle
    if (mc_tick) begin
      if (st_ff.clr) begin
        nxt_st.presc = '0;
        nxt_st.wcnt = '0;
        // A clear written in this same cycle must survive, so the set wins
        nxt_st.clr = clr_req;
      end else if (wdt_run) begin
        nxt_st.presc = presc_tick ? '0 : st_ff.presc + 8'h01;
        if (presc_tick) begin
          nxt_st.wcnt = st_ff.wcnt + 14'h0001;
          if (&st_ff.wcnt) begin
            nxt_st.tout = 1'b1;
            nxt_st.wrst_cnt = WDT_RST_MC;
          end
        end
      end
      if (st_ff.wrst_cnt != 2'h0) begin
        nxt_st.wrst_cnt = st_ff.wrst_cnt - 2'h1;
      end
    end

    // An interrupt wakes idle only; power-down ignores it
    if (irq_pend && st_ff.pm == PM_IDLE) begin
      nxt_st.pm = PM_RUN;
    end

    // With the oscillator stopped only the raw pin can restart it
    if (st_ff.pm == PM_PDOWN && rst_pin) begin
      nxt_st.pm = PM_RUN;
    end

    // System reset: every control bit back to zero, power-off flag kept
    if (rst_act) begin
      nxt_st.pm = PM_RUN;
      nxt_st.gf1 = RST_SFR[PWR_GF1_BIT];
      nxt_st.gf0 = RST_SFR[PWR_GF0_BIT];
      nxt_st.en = RST_SFR[WDT_EN_BIT];
      nxt_st.clr = RST_SFR[WDT_CLR_BIT];
      nxt_st.idle_run = RST_SFR[WDT_IDLE_RUN_BIT];
      nxt_st.ps = RST_SFR[WDT_PS_LSB +: 3];
      nxt_st.presc = '0;
      nxt_st.wcnt = '0;
    end
    nxt_st.sysrst = rst_act;

    nxt_st.cpu_run = (nxt_st.pm == PM_RUN);
    nxt_st.per_run = (nxt_st.pm != PM_PDOWN);
    nxt_st.osc_run = (nxt_st.pm != PM_PDOWN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.pwr_off <= 1'b1;
      st_ff.cpu_run <= 1'b1;
      st_ff.per_run <= 1'b1;
      st_ff.osc_run <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sfr_rdata_ff = st_ff.rdata;
  assign sys_rst_ff = st_ff.sysrst;
  assign cpu_clk_run_ff = st_ff.cpu_run;
  assign periph_clk_run_ff = st_ff.per_run;
  assign osc_run_ff = st_ff.osc_run;
  assign wdt_timeout_ff = st_ff.tout;

endmodule // wdpr_ctrl

// *** tb/wdpr_ctrl_chk.sv ***
`timescale 1ns/100ps
module wdpr_ctrl_chk
  import wdpr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus and pins
  input wire wdpr_bus_t sfr_bus,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic rst_pin,
  input wire logic irq_pend,
  // System control
  input wire logic sys_rst_ff,
  input wire logic cpu_clk_run_ff,
  input wire logic periph_clk_run_ff,
  input wire logic osc_run_ff,
  input wire logic wdt_timeout_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pwr_wr;
    sfr_bus.wr && sfr_bus.addr == ADR_PWR_CTRL && !sys_rst_ff && !rst_pin;
  endsequence
  a_tout_rst: assert property (wdt_timeout_ff |-> ##[0:1] sys_rst_ff [*8])
    else $error("time-out without system reset");
  a_tout_pulse: assert property (wdt_timeout_ff |=> !wdt_timeout_ff)
    else $error("time-out pulse too long");
  a_rdata_quiet: assert property (!$past(sfr_bus.rd) |-> sfr_rdata_ff == 8'h00)
    else $error("read data outside read slot");
  a_idle_entry: assert property (s_pwr_wr ##0 (sfr_bus.wdata[1:0] == 2'h1 && !irq_pend)
    |=> !cpu_clk_run_ff && periph_clk_run_ff)
    else $error("idle entry wrong");
  a_periph_run: assert property (osc_run_ff && $past(osc_run_ff) |-> periph_clk_run_ff)
    else $error("peripheral clock stopped");
  a_sleep_entry: assert property (s_pwr_wr ##0 sfr_bus.wdata[1]
    |=> !osc_run_ff && !cpu_clk_run_ff && !periph_clk_run_ff)
    else $error("power-down entry wrong");
  a_sleep_stay: assert property (!osc_run_ff && !rst_pin |=> !osc_run_ff)
    else $error("power-down left without reset");
  a_idle_wake: assert property (osc_run_ff && !cpu_clk_run_ff && irq_pend
    |=> cpu_clk_run_ff)
    else $error("idle not left on interrupt");
endmodule // wdpr_ctrl_chk
bind wdpr_ctrl wdpr_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .sfr_bus(sfr_bus),
  .sfr_rdata_ff(sfr_rdata_ff), .rst_pin(rst_pin), .irq_pend(irq_pend),
  .sys_rst_ff(sys_rst_ff), .cpu_clk_run_ff(cpu_clk_run_ff),
  .periph_clk_run_ff(periph_clk_run_ff), .osc_run_ff(osc_run_ff),
  .wdt_timeout_ff(wdt_timeout_ff));

// *** tb/wdpr_ctrl_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module wdpr_ctrl_tb
  import wdpr_pkg::*;
;
  logic clk, rst_n, rst_pin, irq_pend, sys_rst, cpu_run, per_run, osc_run, seen, tout;
  wdpr_bus_t bus;
  logic [7:0] rdata, d, c0, c1;
  logic [2:0] sl [8];
  int n_fail = 0;
  int n_tests = 0;
  wdpr_ctrl dut (.clk(clk), .rst_n(rst_n), .sfr_bus(bus), .sfr_rdata_ff(rdata),
    .rst_pin(rst_pin), .irq_pend(irq_pend), .sys_rst_ff(sys_rst), .cpu_clk_run_ff(cpu_run),
    .periph_clk_run_ff(per_run), .osc_run_ff(osc_run), .wdt_timeout_ff(tout));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Two low-byte count reads spaced n+2 cycles apart
  task span(input int n);
    rd(ADR_WCNTL, c0);
    repeat (n) @(posedge clk);
    rd(ADR_WCNTL, c1);
  endtask
  task wake;
    @(posedge clk);
    irq_pend <= 1'b1;
    @(posedge clk);
    irq_pend <= 1'b0;
    #1 `CHK(cpu_run, 1'b1)
  endtask
  task t_regs;
    rd(ADR_PWR_CTRL, d); `CHK(d, 8'h10)
    rd(ADR_WDT_CTRL, d); `CHK(d, 8'h00)
    rd(8'h55, d); `CHK(d, 8'h00)
    wr(ADR_PWR_CTRL, 8'h0C); rd(ADR_PWR_CTRL, d); `CHK(d, 8'h0C)
    wr(ADR_PWR_CTRL, 8'h00); rd(ADR_PWR_CTRL, d); `CHK(d, 8'h00)
    span(100); `CHK(c1, c0)
  endtask
  task t_rate;
    sl = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int k = 0; k < 8; k++) begin
      wr(ADR_WDT_CTRL, {5'h18, sl[k]});
      repeat (20) @(posedge clk);
      // Four counter steps of div*12 clocks each
      span(48 * (2 << k) - 2); `CHK(c1 - c0, 8'h04)
    end
    `CHK(tout, 1'b0)
  endtask
  task t_clear;
    wr(ADR_WDT_CTRL, 8'h80);
    repeat (200) @(posedge clk);
    wr(ADR_WDT_CTRL, 8'hC0);
    repeat (12) @(posedge clk);
    rd(ADR_WCNTL, d); `CHK(d, 8'h00)
    rd(ADR_WDT_CTRL, d); `CHK(d, 8'h80)
    wr(ADR_WDT_CTRL, 8'h00);
    span(100); `CHK(c1, c0)
  endtask
  task t_idle;
    wr(ADR_WDT_CTRL, 8'h80); wr(ADR_PWR_CTRL, 8'h01);
    #1 `CHK({cpu_run, per_run}, 2'b01)
    span(100); `CHK(c1, c0)
    wake;
    wr(ADR_WDT_CTRL, 8'hA0); wr(ADR_PWR_CTRL, 8'h01);
    span(100); `CHK(c1 != c0, 1'b1)
    wake;
  endtask
  task t_pdown;
    wr(ADR_PWR_CTRL, 8'h02);
    #1 `CHK({osc_run, per_run, cpu_run}, 3'b000)
    wake_fail_check();
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (60) @(posedge clk);
    #1 `CHK({osc_run, sys_rst}, 2'b11)
    rd(ADR_WDT_CTRL, d); `CHK(d, 8'h00)
    rd(ADR_WCNTL, d); `CHK(d, 8'h00)
    rd(ADR_PWR_CTRL, d); `CHK(d, 8'h00)
    rst_pin <= 1'b0;
    repeat (40) @(posedge clk);
    #1 `CHK(sys_rst, 1'b0)
  endtask
  // Interrupts must not wake power-down
  task wake_fail_check;
    @(posedge clk);
    irq_pend <= 1'b1;
    repeat (5) @(posedge clk);
    irq_pend <= 1'b0;
    #1 `CHK(osc_run, 1'b0)
  endtask
  task t_glitch;
    seen = 1'b0;
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1 seen = seen | sys_rst;
    end
    `CHK(seen, 1'b0)
  endtask
  task stop_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    stop_test;
  end
  initial begin
    rst_n = 1'b0;
    rst_pin = 1'b0;
    irq_pend = 1'b0;
    bus = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_rate;
    t_clear;
    t_idle;
    t_pdown;
    t_glitch;
    stop_test;
  end
endmodule // wdpr_ctrl_tb
